// >>> core/hbfp_pkg.sv
// Operation
// R1 - Word access uses both lanes; none when both high
// R2 - First style: odd byte upper, even lower
// R3 - Second style: lanes swapped, address n upper
// R4 - Type pin and strobe activity choose configuration
// R5 - Eight or sixteen bit data width
// R6 - Buffer word access only in sixteen bit width
// R7 - Mixed byte/word buffer access advances by bytes
// R8 - Two 64-byte buffers split into 32-byte halves
// R9 - Host sees one half; halves exchange on request
// R10 - Receive half length programmable, 32 down to 2
// R11 - Eight bit width: lower lane only, enable ignored
package hbfp_pkg;

	// ************************************************
	// Address map and buffer geometry
	// ************************************************
	localparam logic [7:0] HBFP_FIFO_ADDR  = 8'h00; // Word-aligned buffer port (bytes 0 and 1)
	localparam int         HBFP_HALF_BYTES = 32;    // One half of either buffer
	localparam int         HBFP_REG_BYTES  = 32;    // Generic register bytes
	localparam logic [5:0] HBFP_RX_LEN_RST = 6'h20; // Receive length after reset
	localparam logic [5:0] HBFP_RX_LEN_MIN = 6'h02; // Shortest receive length
	localparam logic [5:0] HBFP_RX_LEN_MAX = 6'h20; // Longest receive length
	localparam int         HBFP_MUX_CHECK  = 4;     // Cycles for strobe activity to show

	// ************************************************
	// Pin bundle seen at the bus
	// ************************************************
	typedef struct packed {
		logic        chip_select_n;         // Chip select, active low
		logic        read_n;                // Read strobe, active low
		logic        write_n;               // Write strobe, active low
		logic        address_latch;         // Address latch strobe
		logic        interface_type_select; // High: second bus style
		logic        bus_width_select;      // High: sixteen bit width
		logic        upper_byte_enable_n;   // Byte enable in first style
		logic        lane_byte_enable_n;    // Byte enable in second style
		logic [7:0]  address;               // Demultiplexed address
		logic [15:0] data;                  // Data lines in
	} hbfp_pins_t;

endpackage

// >>> core/hbfp_port.sv
`timescale 1ns/1ps
module hbfp_port
	import hbfp_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Host bus pins
	input  wire hbfp_pins_t  pins_in,
	output logic      [15:0] data_out,
	output logic      [1:0]  data_oe_n_out,
	// Internal receive side
	input  wire logic        rx_fill_valid_in,
	input  wire logic [7:0]  rx_fill_data_in,
	input  wire logic        rx_swap_in,
	input  wire logic [5:0]  rx_length_in,
	output logic      [5:0]  rx_fill_level_out,
	output logic      [5:0]  rx_host_level_out,
	// Internal transmit side
	input  wire logic        tx_swap_in,
	input  wire logic [4:0]  tx_drain_index_in,
	output logic      [7:0]  tx_drain_data_out,
	output logic      [5:0]  tx_host_level_out,
	// Status
	output logic             buffer_half_out,
	output logic             mux_mode_out
);

	// ************************************************
	// Pin synchroniser: three stages, change once 2 and 3 agree
	// ************************************************
	hbfp_pins_t p1;                  // First stage, read only by p2
	hbfp_pins_t p2;                  // Second stage
	hbfp_pins_t p3;                  // Third stage
	hbfp_pins_t pq;                  // Filtered pin view
	wire hbfp_pins_t next_pq = (p2 & ~(p2 ^ p3)) | (pq & (p2 ^ p3));

	// Sync chain
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			p1 <= '1;
			p2 <= '1;
			p3 <= '1;
			pq <= '1;
		end else begin
			p1 <= pins_in;
			p2 <= p1;
			p3 <= p2;
			pq <= next_pq;
		end
	end

	// ************************************************
	// Bus configuration and address latch
	// ************************************************
	logic       ale_d;          // Previous latch strobe
	logic       ale_seen;       // One strobe edge seen while type pin low
	logic       mux_mode;       // Strobe seen toggling
	logic [7:0] mux_addr;       // Address caught from data lines
	wire        ale_fall = ale_d & ~pq.address_latch;
	wire        ale_edge = ale_d ^ pq.address_latch;
	wire        moto     = pq.interface_type_select;
	wire        wide     = pq.bus_width_select;
	wire  [7:0] addr     = mux_mode ? mux_addr : pq.address;

	// Toggling strobe with low type pin selects multiplexed style
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ale_d    <= 1'b0;
			ale_seen <= 1'b0;
			mux_mode <= 1'b0;
			mux_addr <= 8'h00;
		end else begin
			ale_d <= pq.address_latch;
			if (moto) begin
				mux_mode <= 1'b0; // see R4
				ale_seen <= 1'b0;
			end else if (ale_edge) begin
				// A static strobe moves once after reset, so only a second edge counts
				ale_seen <= 1'b1;
				mux_mode <= ale_seen; // see R4
			end
			if (ale_fall && !moto) begin
				mux_addr <= pq.data[7:0];
			end
		end
	end

	// ************************************************
	// Lane decode
	// ************************************************
	wire en_n      = moto ? pq.lane_byte_enable_n : pq.upper_byte_enable_n;
	wire a0        = addr[0];
	wire acc_word  = wide & ~en_n & ~a0;                  // see R1
	wire acc_odd   = wide & ~en_n & a0;
	wire acc_even  = wide & en_n & ~a0;
	wire acc_none  = wide & en_n & a0;                    // see R1
	wire lane_hi   = wide & (acc_word | (moto ? acc_even : acc_odd)); // see R2 see R3
	wire lane_lo   = ~wide | acc_word | (moto ? acc_odd : acc_even);  // see R11
	wire first_hi  = wide & (acc_word ? moto : lane_hi);  // see R3
	wire [1:0] nb  = acc_word ? 2'd2 : (acc_none ? 2'd0 : 2'd1); // see R5
	wire is_fifo   = addr[7:1] == HBFP_FIFO_ADDR[7:1];

	// ************************************************
	// Strobe edges
	// ************************************************
	logic rd_act_d;                 // Read strobe last cycle
	logic wr_act_d;                 // Write strobe last cycle
	wire  rd_act = ~pq.chip_select_n & ~pq.read_n;
	wire  wr_act = ~pq.chip_select_n & ~pq.write_n;
	wire  rd_go  = rd_act & ~rd_act_d;
	wire  wr_end = wr_act_d & ~wr_act;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_act_d <= 1'b0;
			wr_act_d <= 1'b0;
		end else begin
			rd_act_d <= rd_act;
			wr_act_d <= wr_act;
		end
	end

	// ************************************************
	// Storage
	// ************************************************
	logic [7:0] rx_mem  [2*HBFP_HALF_BYTES];  // Receive buffer, both halves
	logic [7:0] tx_mem  [2*HBFP_HALF_BYTES];  // Transmit buffer, both halves
	logic [7:0] reg_mem [HBFP_REG_BYTES];     // Register bytes
	logic       rx_half;                      // Host half of receive buffer
	logic       tx_half;                      // Host half of transmit buffer
	logic [5:0] rx_ptr;                       // Host read position
	logic [5:0] rx_fill;                      // Internal fill position
	logic [5:0] tx_ptr;                       // Host write position
	logic [5:0] rx_len;                       // Effective receive length

	// Receive length clamped to its legal span
	wire [5:0] next_rx_len = (rx_length_in < HBFP_RX_LEN_MIN) ? HBFP_RX_LEN_MIN :
		(rx_length_in > HBFP_RX_LEN_MAX) ? HBFP_RX_LEN_MAX : rx_length_in; // see R10

	// Host read bytes from receive half, zero past the length
	wire [5:0] rx_p1   = rx_ptr + 6'd1;
	wire       rx_ok0  = rx_ptr < rx_len;
	wire       rx_ok1  = rx_p1 < rx_len;
	wire [7:0] rx_b0   = rx_ok0 ? rx_mem[{rx_half, rx_ptr[4:0]}] : 8'h00; // see R9
	wire [7:0] rx_b1   = rx_ok1 ? rx_mem[{rx_half, rx_p1[4:0]}] : 8'h00;
	wire [1:0] rx_adv  = (acc_word ? {1'b0, rx_ok0} + {1'b0, rx_ok1} : {1'b0, rx_ok0 & (nb != 2'd0)}); // see R7

	// Register bytes at address and at the odd byte of its word (address with bit 0 set)
	wire [4:0] ri0     = addr[4:0];
	wire [4:0] ri1     = {addr[4:1], 1'b1};
	wire [7:0] rd_b0   = is_fifo ? rx_b0 : reg_mem[ri0];
	wire [7:0] rd_b1   = is_fifo ? rx_b1 : reg_mem[ri1];
	wire [15:0] rdata  = ~wide ? {8'h00, rd_b0} : (first_hi ? {rd_b0, rd_b1} : {rd_b1, rd_b0}); // see R11

	// Write bytes taken from the lane of address n first
	wire [7:0] wr_b0   = first_hi ? pq.data[15:8] : pq.data[7:0];
	wire [7:0] wr_b1   = first_hi ? pq.data[7:0] : pq.data[15:8];
	wire [5:0] tx_p1   = tx_ptr + 6'd1;
	wire       tx_ok0  = tx_ptr < HBFP_HALF_BYTES[5:0];
	wire       tx_ok1  = tx_p1 < HBFP_HALF_BYTES[5:0];
	wire       tx_w0   = wr_end & is_fifo & (nb != 2'd0) & tx_ok0;
	wire       tx_w1   = wr_end & is_fifo & acc_word & tx_ok1; // see R6
	wire       rg_w0   = wr_end & ~is_fifo & (nb != 2'd0);
	wire       rg_w1   = wr_end & ~is_fifo & acc_word;
	wire       rx_put  = rx_fill_valid_in & (rx_fill < HBFP_HALF_BYTES[5:0]);

	// Memory writes, no reset needed
	always_ff @(posedge clk_in) begin
		if (rx_put) begin
			rx_mem[{~rx_half, rx_fill[4:0]}] <= rx_fill_data_in; // see R8
		end
		if (tx_w0) begin
			tx_mem[{tx_half, tx_ptr[4:0]}] <= wr_b0; // see R7
		end
		if (tx_w1) begin
			tx_mem[{tx_half, tx_p1[4:0]}] <= wr_b1;
		end
		if (rg_w0) begin
			reg_mem[ri0] <= wr_b0;
		end
		if (rg_w1) begin
			reg_mem[ri1] <= wr_b1;
		end
	end

	// Buffer pointers and half exchange
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_half <= 1'b0;
			tx_half <= 1'b0;
			rx_ptr  <= 6'h00;
			rx_fill <= 6'h00;
			tx_ptr  <= 6'h00;
			rx_len  <= HBFP_RX_LEN_RST; // see R10
		end else begin
			// New length takes effect with the next half, so the host pointer never passes it
			if (rx_swap_in) begin
				rx_len  <= next_rx_len; // see R10
				rx_half <= ~rx_half; // see R9
				rx_ptr  <= 6'h00;
				rx_fill <= 6'h00;
			end else begin
				if (rd_go && is_fifo) begin
					rx_ptr <= rx_ptr + {4'h0, rx_adv}; // see R7
				end
				if (rx_put) begin
					rx_fill <= rx_fill + 6'd1;
				end
			end
			if (tx_swap_in) begin
				tx_half <= ~tx_half; // see R9
				tx_ptr  <= 6'h00;
			end else begin
				tx_ptr <= tx_ptr + {5'h00, tx_w0} + {5'h00, tx_w1};
			end
		end
	end

	// ************************************************
	// Output registers
	// ************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_out          <= 16'h0000;
			data_oe_n_out     <= 2'b11;
			tx_drain_data_out <= 8'h00;
			rx_fill_level_out <= 6'h00;
			rx_host_level_out <= 6'h00;
			tx_host_level_out <= 6'h00;
			buffer_half_out   <= 1'b0;
			mux_mode_out      <= 1'b0;
		end else begin
			if (rd_go) begin
				data_out <= rdata;
			end
			// Drive only the lanes that carry the access
			data_oe_n_out     <= rd_act ? {~lane_hi, ~lane_lo} : 2'b11; // see R1 see R2 see R3 see R11
			tx_drain_data_out <= tx_mem[{~tx_half, tx_drain_index_in}];
			rx_fill_level_out <= rx_fill;
			rx_host_level_out <= rx_ptr;
			tx_host_level_out <= tx_ptr;
			buffer_half_out   <= rx_half;
			mux_mode_out      <= mux_mode;
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	sequence s_read_start;
		rd_go ##0 rd_act;
	endsequence

	sequence s_ale_toggle;
		(!moto && ale_seen) ##0 ale_edge;
	endsequence

	property p_word_lanes;
		@(posedge clk_in) disable iff (rst_in)
		(s_read_start ##0 acc_word) |=> (data_oe_n_out == 2'b00);
	endproperty
	a_word_lanes: assert property (p_word_lanes) else $error("word read not on both lanes"); // see R1

	property p_no_transfer;
		@(posedge clk_in) disable iff (rst_in)
		(s_read_start ##0 acc_none ##0 !rx_swap_in) |=> (data_oe_n_out == 2'b11) && $stable(rx_ptr);
	endproperty
	a_no_transfer: assert property (p_no_transfer) else $error("disabled access used lanes"); // see R1

	property p_first_odd;
		@(posedge clk_in) disable iff (rst_in)
		(rd_act && !moto && acc_odd) |=> (data_oe_n_out == 2'b01);
	endproperty
	a_first_odd: assert property (p_first_odd) else $error("odd byte off upper lane"); // see R2

	property p_second_odd;
		@(posedge clk_in) disable iff (rst_in)
		(rd_act && moto && acc_odd) |=> (data_oe_n_out == 2'b10);
	endproperty
	a_second_odd: assert property (p_second_odd) else $error("odd byte off lower lane"); // see R3

	property p_mux_seen;
		@(posedge clk_in) disable iff (rst_in)
		(s_ale_toggle ##1 !moto [*2]) |-> ##[0:4] mux_mode_out;
	endproperty
	a_mux_seen: assert property (p_mux_seen) else $error("strobe toggling not seen"); // see R4

	property p_narrow_lane;
		@(posedge clk_in) disable iff (rst_in)
		(rd_act && !wide) |=> (data_oe_n_out == 2'b10);
	endproperty
	a_narrow_lane: assert property (p_narrow_lane) else $error("narrow read used upper lane"); // see R11 R5

	property p_narrow_step;
		@(posedge clk_in) disable iff (rst_in)
		(!wide && !tx_swap_in) |=> (tx_ptr - $past(tx_ptr)) <= 6'd1;
	endproperty
	a_narrow_step: assert property (p_narrow_step) else $error("narrow write moved two bytes"); // see R6

	property p_rx_step;
		@(posedge clk_in) disable iff (rst_in)
		(rd_go && is_fifo && !rx_swap_in) |=> (rx_ptr == $past(rx_ptr) + {4'h0, $past(rx_adv)});
	endproperty
	a_rx_step: assert property (p_rx_step) else $error("receive pointer step wrong"); // see R7

	property p_swap;
		@(posedge clk_in) disable iff (rst_in)
		rx_swap_in |=> (rx_half != $past(rx_half)) && (rx_ptr == 6'h00) ##1 (buffer_half_out == rx_half);
	endproperty
	a_swap: assert property (p_swap) else $error("halves not exchanged"); // see R9 R8

	property p_rx_len;
		@(posedge clk_in) disable iff (rst_in)
		1'b1 |-> (rx_len >= HBFP_RX_LEN_MIN) && (rx_len <= HBFP_RX_LEN_MAX) && (rx_ptr <= rx_len);
	endproperty
	a_rx_len: assert property (p_rx_len) else $error("receive length out of span"); // see R10

endmodule

// >>> bench/hbfp_host_model.sv
`timescale 1ns/1ps
module hbfp_host_model
	import hbfp_pkg::*;
(
	// Clock
	input  wire logic        clk_in,
	// Pins toward the port
	output hbfp_pins_t       pins_out,
	// Answer from the port
	input  wire logic [15:0] data_in,
	input  wire logic [1:0]  oe_n_in
);
	// ****
	// Idle bus at time zero
	// ****
	initial begin
		pins_out = '1;
		pins_out.address_latch = 1'b0;
		pins_out.interface_type_select = 1'b0;
		pins_out.data = 16'h0000;
	end

	// Configuration pins, then time for the sync chain
	task automatic set_mode(input logic style, input logic wide);
		@(posedge clk_in);
		pins_out.interface_type_select <= style;
		pins_out.bus_width_select      <= wide;
		repeat (8) @(posedge clk_in);
	endtask

	// Toggling strobe marks a multiplexed bus, address on the low data lines
	task automatic toggle_latch(input logic [7:0] a);
		@(posedge clk_in);
		pins_out.data <= {8'h00, a};
		repeat (2) begin
			@(posedge clk_in);
			pins_out.address_latch <= 1'b1;
			repeat (6) @(posedge clk_in);
			pins_out.address_latch <= 1'b0;
			repeat (6) @(posedge clk_in);
		end
	endtask

	// One bus cycle; enables drive both style pins alike
	task automatic access(input logic wr, input logic [7:0] addr, input logic en_n,
		input logic [15:0] wdata, output logic [15:0] rdata, output logic [1:0] oe_n);
		@(posedge clk_in);
		pins_out.address             <= addr;
		pins_out.upper_byte_enable_n <= en_n;
		pins_out.lane_byte_enable_n  <= en_n;
		pins_out.data                <= wr ? wdata : ~pins_out.data;
		pins_out.chip_select_n       <= 1'b0;
		pins_out.write_n             <= ~wr;
		pins_out.read_n              <= wr;
		repeat (8) @(posedge clk_in);
		rdata = data_in;
		oe_n  = oe_n_in;
		pins_out.chip_select_n <= 1'b1;
		pins_out.write_n       <= 1'b1;
		pins_out.read_n        <= 1'b1;
		repeat (7) @(posedge clk_in);
		// Released lines no longer show the last value
		pins_out.data <= ~pins_out.data;
	endtask
endmodule

// >>> bench/hbfp_port_tb.sv
`timescale 1ns/1ps
module hbfp_port_tb
	import hbfp_pkg::*;
;
	// ****
	// Signals
	// ****
	logic        clk_in = 1'b0;      // Core clock
	logic        rst_in = 1'b1;      // Reset
	hbfp_pins_t  pins;               // Bus pins
	logic [15:0] data_out;           // Read data
	logic [1:0]  data_oe_n_out;      // Lane drive, low active
	logic        rx_fill_valid_in = 1'b0;
	logic [7:0]  rx_fill_data_in  = 8'h00;
	logic        rx_swap_in       = 1'b0;
	logic [5:0]  rx_length_in     = 6'h20;
	logic [5:0]  rx_fill_level_out;
	logic [5:0]  rx_host_level_out;
	logic        tx_swap_in       = 1'b0;
	logic [4:0]  tx_drain_index_in = 5'h00;
	logic [7:0]  tx_drain_data_out;
	logic [5:0]  tx_host_level_out;
	logic        buffer_half_out;
	logic        mux_mode_out;
	int          num_errors = 0;     // Mismatches
	int          total_checks = 0;   // Comparisons
	logic [15:0] rdat;               // Last read data
	logic [1:0]  roe;                // Last lane drive
	logic [7:0]  tx_exp [3] = '{8'h11, 8'h22, 8'h33};

	always #2 clk_in = ~clk_in;

	hbfp_port u_dut (.clk_in(clk_in), .rst_in(rst_in), .pins_in(pins), .data_out(data_out),
		.data_oe_n_out(data_oe_n_out), .rx_fill_valid_in(rx_fill_valid_in),
		.rx_fill_data_in(rx_fill_data_in), .rx_swap_in(rx_swap_in), .rx_length_in(rx_length_in),
		.rx_fill_level_out(rx_fill_level_out), .rx_host_level_out(rx_host_level_out),
		.tx_swap_in(tx_swap_in), .tx_drain_index_in(tx_drain_index_in),
		.tx_drain_data_out(tx_drain_data_out), .tx_host_level_out(tx_host_level_out),
		.buffer_half_out(buffer_half_out), .mux_mode_out(mux_mode_out));

	hbfp_host_model u_host (.clk_in(clk_in), .pins_out(pins), .data_in(data_out), .oe_n_in(data_oe_n_out));

	// ****
	// Compare and access tasks
	// ****
	task automatic chk_data(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_small(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic en_n);
		u_host.access(1'b0, a, en_n, 16'h0000, rdat, roe);
	endtask

	task automatic wr(input logic [7:0] a, input logic en_n, input logic [15:0] d);
		u_host.access(1'b1, a, en_n, d, rdat, roe);
	endtask

	task automatic pulse(input logic sel_rx);
		@(posedge clk_in);
		if (sel_rx) begin
			rx_swap_in <= 1'b1;
		end else begin
			tx_swap_in <= 1'b1;
		end
		@(posedge clk_in);
		rx_swap_in <= 1'b0;
		tx_swap_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		#40000;
		num_errors++;
		give_verdict();
	end

	// ****
	// Tests
	// ****
	initial begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		chk_small("oe after reset", 8'h03, {6'h00, data_oe_n_out});
		u_host.set_mode(1'b0, 1'b1);
		wr(8'h04, 1'b0, 16'hA55A);
		rd(8'h04, 1'b0);
		chk_data("word", 16'hA55A, rdat);
		chk_small("word oe", 8'h00, {6'h00, roe});
		rd(8'h05, 1'b0);
		chk_small("odd byte", 8'hA5, rdat[15:8]);
		chk_small("odd oe", 8'h01, {6'h00, roe});
		rd(8'h04, 1'b1);
		chk_small("even byte", 8'h5A, rdat[7:0]);
		chk_small("even oe", 8'h02, {6'h00, roe});
		rd(8'h05, 1'b1);
		chk_small("no transfer oe", 8'h03, {6'h00, roe});
		// Mixed word and byte writes into the transmit buffer
		wr(8'h00, 1'b0, 16'h2211);
		chk_small("tx level word", 8'h02, {2'h0, tx_host_level_out});
		wr(8'h00, 1'b1, 16'h0033);
		chk_small("tx level byte", 8'h03, {2'h0, tx_host_level_out});
		pulse(1'b0);
		chk_small("tx level swap", 8'h00, {2'h0, tx_host_level_out});
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_in);
			tx_drain_index_in <= 5'(i);
			repeat (2) @(posedge clk_in);
			chk_small("drain", tx_exp[i], tx_drain_data_out);
		end
		// Receive half cut to its shortest length
		rx_length_in <= 6'h02;
		for (int i = 1; i < 5; i++) begin
			@(posedge clk_in);
			rx_fill_valid_in <= 1'b1;
			rx_fill_data_in  <= 8'h40 + 8'(i);
		end
		@(posedge clk_in);
		rx_fill_valid_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		chk_small("rx fill", 8'h04, {2'h0, rx_fill_level_out});
		pulse(1'b1);
		chk_small("rx half", 8'h01, {7'h00, buffer_half_out});
		rd(8'h00, 1'b0);
		chk_data("rx word", 16'h4241, rdat);
		chk_small("rx pos", 8'h02, {2'h0, rx_host_level_out});
		rd(8'h00, 1'b1);
		chk_small("rx past length", 8'h00, rdat[7:0]);
		chk_small("rx pos held", 8'h02, {2'h0, rx_host_level_out});
		// Second bus style swaps the lanes
		u_host.set_mode(1'b1, 1'b1);
		rd(8'h04, 1'b0);
		chk_data("word swapped", 16'h5AA5, rdat);
		rd(8'h05, 1'b0);
		chk_small("odd swapped", 8'hA5, rdat[7:0]);
		chk_small("odd swapped oe", 8'h02, {6'h00, roe});
		rd(8'h04, 1'b1);
		chk_small("even swapped", 8'h5A, rdat[15:8]);
		chk_small("even swapped oe", 8'h01, {6'h00, roe});
		wr(8'h06, 1'b0, 16'h1234);
		// Narrow bus: lower lane only
		u_host.set_mode(1'b0, 1'b0);
		rd(8'h05, 1'b0);
		chk_small("narrow byte", 8'hA5, rdat[7:0]);
		chk_small("narrow oe", 8'h02, {6'h00, roe});
		rd(8'h06, 1'b0);
		chk_small("swapped write", 8'h12, rdat[7:0]);
		wr(8'h01, 1'b1, 16'h4477);
		chk_small("narrow tx level", 8'h01, {2'h0, tx_host_level_out});
		// Strobe activity selects multiplexed addressing
		chk_small("mux idle", 8'h00, {7'h00, mux_mode_out});
		u_host.toggle_latch(8'h05);
		chk_small("mux on", 8'h01, {7'h00, mux_mode_out});
		rd(8'h00, 1'b1);
		chk_small("mux byte", 8'hA5, rdat[7:0]);
		u_host.set_mode(1'b1, 1'b1);
		chk_small("mux off", 8'h00, {7'h00, mux_mode_out});
		give_verdict();
	end
endmodule
